// >>> adst_map.vh
`ifndef ADST_MAP_VH
`define ADST_MAP_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADST_ADDR_TEST_SEL      8'h0D
`define ADST_ADDR_SELF_CHECK    8'h0E
`define ADST_RESET_TEST_SEL     8'h00
`define ADST_RESET_BYTE         8'h00

// Output test register fields
`define ADST_TSEL_MODE_MSB      3
`define ADST_TSEL_MODE_LSB      0
`define ADST_TSEL_LONG_RST      4
`define ADST_TSEL_SHORT_RST     5

// Self-test register fields
`define ADST_SC_RUN_PASS        0
`define ADST_SC_PN_RESTART      2

// ****************************************************************
// Output test modes
// ****************************************************************
`define ADST_MODE_OFF           4'h0
`define ADST_MODE_MIDSCALE      4'h1
`define ADST_MODE_POS_FS        4'h2
`define ADST_MODE_NEG_FS        4'h3
`define ADST_MODE_CHECKER       4'h4
`define ADST_MODE_PN_LONG       4'h5
`define ADST_MODE_PN_SHORT      4'h6
`define ADST_MODE_WORD_TOGGLE   4'h7

`define ADST_PAT_MIDSCALE       8'h80
`define ADST_PAT_POS_FS         8'hFF
`define ADST_PAT_NEG_FS         8'h00
`define ADST_PAT_CHECK_A        8'h55
`define ADST_PAT_CHECK_B        8'hAA
`define ADST_PAT_ONES           8'hFF
`define ADST_PAT_ZEROS          8'h00

// ****************************************************************
// Pseudorandom generators
// ****************************************************************
`define ADST_SELF_PN_W          16
`define ADST_SELF_PN_TAPS       16'hB400
`define ADST_SELF_PN_SEED       16'hFFFF
`define ADST_LONG_PN_W          23
`define ADST_LONG_PN_TAPS       23'h420000
`define ADST_LONG_PN_SEED       23'h7FFFFF
`define ADST_SHORT_PN_W         9
`define ADST_SHORT_PN_TAPS      9'h110
`define ADST_SHORT_PN_SEED      9'h1FF

// ****************************************************************
// Self-test signature
// ****************************************************************
`define ADST_BIST_LAST          9'h1FF
`define ADST_CRC_INIT           16'hFFFF
`define ADST_CRC_POLY           16'h1021
`define ADST_SIG_EXPECT         16'h0000

// ****************************************************************
// Pipeline correction
// ****************************************************************
`define ADST_STAGES             7
`define ADST_CODE_W             16
`define ADST_FLASH_LSB          14
`define ADST_SAMPLE_MAX         9'h0FF

`endif

// >>> adst_pn_gen.v
`timescale 1ns/1ps
// Fibonacci LFSR; all-ones seed keeps it out of the lock-up state
module adst_pn_gen #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] TAPS = 16'hB400,
    parameter [WIDTH-1:0] SEED = 16'hFFFF
) (
    input  wire             ref_clk,
    input  wire             arst_n,
    input  wire             clkEn,
    input  wire             step,
    input  wire             restart,
    output reg  [WIDTH-1:0] state_r
);

    wire feedback;

    assign feedback = ^(state_r & TAPS);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= SEED;
        end else if (clkEn) begin
            if (restart) begin
                state_r <= SEED;
            end else if (step) begin
                state_r <= {state_r[WIDTH-2:0], feedback};
            end
        end
    end

endmodule

// >>> adst_core.v
`timescale 1ns/1ps
`include "adst_map.vh"
// Operation
// - High level on the output-disable pin floats both channel buses.
// - Power-down holds both output buses in high impedance.
// - Both channels advance together on the one encode clock.
// - Correction merges pipeline stage codes into one 8-bit sample per channel.
// - Self-test injects pseudorandom data at converter output into both channels.
// - CRC signature accumulates over the data at the datapath end.
// - Self-test runs exactly 512 unstalled cycles then stops by itself.
// - Matching signature sets bit 0 of the self-test register.
// - Mismatching signature clears bit 0 of the self-test register.
// - Outputs stay connected during self-test, showing the sequence.
// - Writing 0x05 starts self-test with run bit and generator restart.
// - Run bit takes the pass/fail result when self-test completes.
// - Start with restart bit clear continues the generator from its last state.
// - Without restart the signature differs, so pass/fail is meaningless.
// - Outside a self-test run, any output test mode replaces analog data with the selected pattern.
// - Some patterns pass through output formatting, others bypass it.
// - Bits 4 and 5 of the output test register reset pattern generators.
// - Test modes ignore the analog input but need the encode clock.
// - Output test register holds eight bits; self-test register keeps only bits 0 and 2.
module adst_core #(
    parameter [15:0] EXPECT_SIG = `ADST_SIG_EXPECT
) (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        clkEn,
    input  wire        outDisable,
    input  wire        powerDown,
    input  wire        fmtTwosComp,
    input  wire [15:0] stageCodeA,
    input  wire [15:0] stageCodeB,
    input  wire        regWrEn,
    input  wire        regRdEn,
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWrData,
    output reg  [7:0]  regRdData_r,
    output reg  [7:0]  chAData_r,
    output reg  [7:0]  chBData_r,
    output reg         chAOe_r,
    output reg         chBOe_r,
    output reg         outValid_r,
    input  wire        outReady,
    output reg         selfCheckBusy_r
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg  [2:0] pinMeta_r;
    reg  [2:0] pinSync_r;
    wire       oeBarS;
    wire       pwrDnS;
    wire       twosS;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_r <= 3'h0;
            pinSync_r <= 3'h0;
        end else if (clkEn) begin
            pinMeta_r <= {fmtTwosComp, powerDown, outDisable};
            pinSync_r <= pinMeta_r;
        end
    end

    assign oeBarS = pinSync_r[0];
    assign pwrDnS = pinSync_r[1];
    assign twosS  = pinSync_r[2];

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0] testSel_r;
    reg        pnRestart_r;
    reg        runPass_r;
    reg  [1:0] state_r;
    reg  [8:0] cycleCnt_r;
    reg  [15:0] crc_r;
    reg        inReady_r;
    wire       adv;
    wire       startReq;
    wire [3:0] mode;
    wire       wrSel;
    wire       wrCheck;

    // Whole datapath stalls on a full buffer so no word is dropped
    assign adv     = clkEn & inReady_r;
    assign wrSel   = regWrEn && (regAddr == `ADST_ADDR_TEST_SEL);
    assign wrCheck = regWrEn && (regAddr == `ADST_ADDR_SELF_CHECK);
    assign startReq = wrCheck && regWrData[`ADST_SC_RUN_PASS] && (state_r == ST_IDLE);
    assign mode    = testSel_r[`ADST_TSEL_MODE_MSB:`ADST_TSEL_MODE_LSB];

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            testSel_r   <= `ADST_RESET_TEST_SEL;
            pnRestart_r <= 1'b0;
        end else if (clkEn) begin
            if (wrSel) begin
                testSel_r <= regWrData;
            end
            if (wrCheck) begin
                pnRestart_r <= regWrData[`ADST_SC_PN_RESTART];
            end
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData_r <= `ADST_RESET_BYTE;
        end else if (clkEn && regRdEn) begin
            case (regAddr)
                `ADST_ADDR_TEST_SEL: begin
                    regRdData_r <= testSel_r;
                end
                `ADST_ADDR_SELF_CHECK: begin
                    regRdData_r <= {5'h00, pnRestart_r, 1'b0, runPass_r};
                end
                default: begin
                    regRdData_r <= `ADST_RESET_BYTE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pseudorandom sources
    // ****************************************************************
    wire [15:0] selfPn;
    wire [22:0] longPn;
    wire [8:0]  shortPn;
    wire        selfRestart;

    // Restart only when requested; otherwise the run resumes the old state
    assign selfRestart = startReq && regWrData[`ADST_SC_PN_RESTART];

    adst_pn_gen #(
        .WIDTH (`ADST_SELF_PN_W),
        .TAPS  (`ADST_SELF_PN_TAPS),
        .SEED  (`ADST_SELF_PN_SEED)
    ) uSelfPn (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .step    (adv && (state_r == ST_RUN)),
        .restart (selfRestart),
        .state_r (selfPn)
    );

    adst_pn_gen #(
        .WIDTH (`ADST_LONG_PN_W),
        .TAPS  (`ADST_LONG_PN_TAPS),
        .SEED  (`ADST_LONG_PN_SEED)
    ) uLongPn (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .step    (adv && (mode == `ADST_MODE_PN_LONG)),
        .restart (testSel_r[`ADST_TSEL_LONG_RST]),
        .state_r (longPn)
    );

    adst_pn_gen #(
        .WIDTH (`ADST_SHORT_PN_W),
        .TAPS  (`ADST_SHORT_PN_TAPS),
        .SEED  (`ADST_SHORT_PN_SEED)
    ) uShortPn (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .step    (adv && (mode == `ADST_MODE_PN_SHORT)),
        .restart (testSel_r[`ADST_TSEL_SHORT_RST]),
        .state_r (shortPn)
    );

    // ****************************************************************
    // Stage alignment and digital correction
    // ****************************************************************
    wire [31:0] codesIn;
    wire [27:0] aligned;
    reg  [15:0] corrected_r;

    assign codesIn = {stageCodeB, stageCodeA};

    genvar ch;
    genvar st;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
            for (st = 0; st < `ADST_STAGES; st = st + 1) begin : gStage
                // Earlier stages resolve earlier, so they wait longer
                reg  [2*(`ADST_STAGES-st)-1:0] dly_r;
                wire [2*(`ADST_STAGES-st)+1:0] dlyShift;
                assign dlyShift = {dly_r, codesIn[16*ch+2*st+1 -: 2]};
                always @(posedge ref_clk or negedge arst_n) begin
                    if (!arst_n) begin
                        dly_r <= {(2*(`ADST_STAGES-st)){1'b0}};
                    end else if (adv) begin
                        dly_r <= dlyShift[2*(`ADST_STAGES-st)-1:0];
                    end
                end
                assign aligned[14*ch+2*st+1 -: 2] = dly_r[2*(`ADST_STAGES-st)-1 -: 2];
            end

            // One bit of overlap per stage: shift each code by one less
            reg [8:0] sum;
            integer   k;
            always @* begin
                sum = {7'h00, codesIn[16*ch+`ADST_FLASH_LSB+1 -: 2]};
                for (k = 0; k < `ADST_STAGES; k = k + 1) begin
                    sum = sum + ({7'h00, aligned[14*ch+2*k+1 -: 2]} << (`ADST_STAGES - 1 - k));
                end
            end

            always @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    corrected_r[8*ch+7 -: 8] <= 8'h00;
                end else if (adv) begin
                    // Overrange clamps instead of wrapping
                    if (sum > `ADST_SAMPLE_MAX) begin
                        corrected_r[8*ch+7 -: 8] <= 8'hFF;
                    end else begin
                        corrected_r[8*ch+7 -: 8] <= sum[7:0];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Source selection and output formatting
    // ****************************************************************
    reg        toggle_r;
    reg [15:0] srcWord;
    reg        doFormat;
    reg [15:0] pushWord;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggle_r <= 1'b0;
        end else if (adv) begin
            toggle_r <= ~toggle_r;
        end
    end

    // Analog codes are not read in any test mode
    always @* begin
        doFormat = 1'b1;
        srcWord  = corrected_r;
        if (state_r == ST_RUN) begin
            srcWord = selfPn;
        end else begin
            case (mode)
                `ADST_MODE_OFF: begin
                    srcWord = corrected_r;
                end
                `ADST_MODE_MIDSCALE: begin
                    srcWord = {2{`ADST_PAT_MIDSCALE}};
                end
                `ADST_MODE_POS_FS: begin
                    srcWord = {2{`ADST_PAT_POS_FS}};
                end
                `ADST_MODE_NEG_FS: begin
                    srcWord = {2{`ADST_PAT_NEG_FS}};
                end
                `ADST_MODE_CHECKER: begin
                    doFormat = 1'b0;
                    srcWord  = toggle_r ? {2{`ADST_PAT_CHECK_B}} : {2{`ADST_PAT_CHECK_A}};
                end
                `ADST_MODE_PN_LONG: begin
                    doFormat = 1'b0;
                    srcWord  = {2{longPn[7:0]}};
                end
                `ADST_MODE_PN_SHORT: begin
                    doFormat = 1'b0;
                    srcWord  = {2{shortPn[7:0]}};
                end
                `ADST_MODE_WORD_TOGGLE: begin
                    doFormat = 1'b0;
                    srcWord  = toggle_r ? {2{`ADST_PAT_ONES}} : {2{`ADST_PAT_ZEROS}};
                end
                default: begin
                    srcWord = corrected_r;
                end
            endcase
        end
        pushWord = srcWord;
        if (doFormat && twosS) begin
            pushWord = srcWord ^ 16'h8080;
        end
    end

    // ****************************************************************
    // Self-test sequencer and signature
    // ****************************************************************
    function [15:0] crcStep;
        input [15:0] crcIn;
        input [15:0] data;
        integer      b;
        reg   [15:0] c;
        begin
            c = crcIn;
            for (b = 15; b >= 0; b = b - 1) begin
                if (c[15] ^ data[b]) begin
                    c = {c[14:0], 1'b0} ^ `ADST_CRC_POLY;
                end else begin
                    c = {c[14:0], 1'b0};
                end
            end
            crcStep = c;
        end
    endfunction

    wire [15:0] crc_nxt;

    assign crc_nxt = crcStep(crc_r, pushWord);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r         <= ST_IDLE;
            cycleCnt_r      <= 9'h000;
            crc_r           <= `ADST_CRC_INIT;
            runPass_r       <= 1'b0;
            selfCheckBusy_r <= 1'b0;
        end else if (clkEn) begin
            case (state_r)
                ST_IDLE: begin
                    if (startReq) begin
                        state_r         <= ST_RUN;
                        cycleCnt_r      <= 9'h000;
                        crc_r           <= `ADST_CRC_INIT;
                        runPass_r       <= 1'b1;
                        selfCheckBusy_r <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (adv) begin
                        crc_r      <= crc_nxt;
                        cycleCnt_r <= cycleCnt_r + 9'h001;
                        if (cycleCnt_r == `ADST_BIST_LAST) begin
                            state_r         <= ST_IDLE;
                            selfCheckBusy_r <= 1'b0;
                            // A resumed sequence fails here by design
                            runPass_r <= (crc_nxt == EXPECT_SIG);
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Two-entry output buffer and pin drive
    // ****************************************************************
    reg  [15:0] skid_r;
    reg         skidValid_r;
    wire        pop;

    assign pop = outValid_r & outReady;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chAData_r   <= 8'h00;
            chBData_r   <= 8'h00;
            outValid_r  <= 1'b0;
            skid_r      <= 16'h0000;
            skidValid_r <= 1'b0;
            inReady_r   <= 1'b1;
        end else if (clkEn) begin
            if (pop && skidValid_r) begin
                {chBData_r, chAData_r} <= skid_r;
                skidValid_r            <= 1'b0;
                inReady_r              <= 1'b1;
            end else if (pop || !outValid_r) begin
                {chBData_r, chAData_r} <= pushWord;
                outValid_r             <= 1'b1;
            end else if (inReady_r) begin
                skid_r      <= pushWord;
                skidValid_r <= 1'b1;
                inReady_r   <= 1'b0;
            end
        end
    end

    // Self-test does not touch the enables
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chAOe_r <= 1'b0;
            chBOe_r <= 1'b0;
        end else if (clkEn) begin
            chAOe_r <= ~oeBarS & ~pwrDnS;
            chBOe_r <= ~oeBarS & ~pwrDnS;
        end
    end

endmodule

// >>> adst_checker.sv
`timescale 1ns/1ps
module adst_checker (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       clkEn,
    input wire logic       outDisable,
    input wire logic       powerDown,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_r,
    input wire logic [7:0] chAData_r,
    input wire logic [7:0] chBData_r,
    input wire logic       chAOe_r,
    input wire logic       chBOe_r,
    input wire logic       outValid_r,
    input wire logic       outReady,
    input wire logic       selfCheckBusy_r
);
    localparam int RUN_LEN = 512;
    logic [9:0] runCnt_r;
    logic       stall_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Stalled runs are excused from the exact length check
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            runCnt_r <= 10'h000;
            stall_r  <= 1'b0;
        end else begin
            runCnt_r <= selfCheckBusy_r ? runCnt_r + 10'h001 : 10'h000;
            stall_r  <= selfCheckBusy_r & (stall_r | !clkEn | !outReady);
        end
    end
    sequence s_start;
        clkEn && regWrEn && regAddr == 8'h0E && regWrData[0] && !selfCheckBusy_r;
    endsequence
    sequence s_finish;
        $fell(selfCheckBusy_r) && !stall_r;
    endsequence
    property p_start; s_start |=> selfCheckBusy_r; endproperty
    property p_run_len; s_finish |-> runCnt_r == RUN_LEN; endproperty
    property p_oe_dis; (clkEn && outDisable)[*3] |=> !chAOe_r && !chBOe_r; endproperty
    property p_oe_pd; (clkEn && powerDown)[*3] |=> !chAOe_r && !chBOe_r; endproperty
    property p_oe_on; (clkEn && !outDisable && !powerDown)[*3] |=> chAOe_r && chBOe_r; endproperty
    property p_hold;
        outValid_r && !outReady |=> outValid_r && $stable(chAData_r) && $stable(chBData_r);
    endproperty
    property p_unmapped;
        clkEn && regRdEn && regAddr != 8'h0D && regAddr != 8'h0E |=> regRdData_r == 8'h00;
    endproperty
    property p_sc_read;
        clkEn && regRdEn && regAddr == 8'h0E |=> regRdData_r[7:3] == 5'h00 && !regRdData_r[1];
    endproperty
    a_start: assert property (p_start) else $error("self-test did not start");
    a_run_len: assert property (p_run_len) else $error("self-test length wrong");
    a_oe_dis: assert property (p_oe_dis) else $error("bus driven while disabled");
    a_oe_pd: assert property (p_oe_pd) else $error("bus driven in power-down");
    a_oe_on: assert property (p_oe_on) else $error("bus not driven");
    a_hold: assert property (p_hold) else $error("held word changed");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_sc_read: assert property (p_sc_read) else $error("unused bits set");
endmodule
bind adst_core adst_checker chk_u (.ref_clk, .arst_n, .clkEn, .outDisable, .powerDown, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData_r, .chAData_r, .chBData_r, .chAOe_r, .chBOe_r, .outValid_r, .outReady,
    .selfCheckBusy_r);

// >>> adst_rx_model.sv
`timescale 1ns/1ps
module adst_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    input  wire logic        stallEn,
    input  wire logic [7:0]  chA,
    input  wire logic [7:0]  chB,
    input  wire logic        aOe,
    input  wire logic        bOe,
    input  wire logic        outValid,
    output logic             outReady,
    output logic             rxStrobe,
    output logic [15:0]      rxWord
);
    integer      seed  = 32'hE50A13F8;
    logic [15:0] lastW = 16'h0000;
    // A floating bus shows no stale word
    wire  [15:0] busW  = {bOe ? chB : ~lastW[15:8], aOe ? chA : ~lastW[7:0]};
    initial outReady = 1'b1;
    always @(negedge ref_clk) outReady <= !stallEn || ($random(seed) % 3 != 0);
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxStrobe <= 1'b0;
        end else begin
            rxStrobe <= outValid && outReady && clkEn;
            if (outValid && outReady && clkEn) begin
                rxWord <= busW;
                lastW  <= busW;
            end
        end
    end
endmodule

// >>> adc_datapath_self_test_tb.sv
`timescale 1ns/1ps
`include "adst_map.vh"
module adc_datapath_self_test_tb;
    logic        ref_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, outDisable = 1'b0, powerDown = 1'b0;
    logic        fmtTwosComp = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, stallEn = 1'b0, randStage = 1'b0;
    logic        syncWait = 1'b0, rdPend = 1'b0;
    logic [15:0] stageCodeA = 16'h0000, stageCodeB = 16'h0000, pn;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00;
    wire  [7:0]  regRdData_r, chAData_r, chBData_r;
    wire         chAOe_r, chBOe_r, outValid_r, outReady, selfCheckBusy_r, rxStrobe;
    wire  [15:0] rxWord;
    integer      seed = 32'hE50A13F8, numErrors = 0, nTests = 0, i, k;
    logic [15:0] expQ[$];
    logic [7:0]  rdQ[$];
    logic [16:0] modeTab [0:9] = '{{8'h01, 1'b0, 8'h80}, {8'h01, 1'b1, 8'h00}, {8'h02, 1'b0, 8'hFF},
        {8'h02, 1'b1, 8'h7F}, {8'h03, 1'b0, 8'h00}, {8'h03, 1'b1, 8'h80}, {8'h04, 1'b1, 8'h55},
        {8'h07, 1'b1, 8'h00}, {8'h15, 1'b1, 8'hFF}, {8'h26, 1'b1, 8'hFF}};

    function automatic [15:0] pnStep(input [15:0] s);
        pnStep = {s[14:0], ^(s & `ADST_SELF_PN_TAPS)};
    endfunction
    function automatic [15:0] sigCalc(input integer n);
        reg [15:0] p;
        reg [15:0] c;
        integer    j;
        integer    b;
        p = `ADST_SELF_PN_SEED;
        c = `ADST_CRC_INIT;
        for (j = 0; j < n; j = j + 1) begin
            for (b = 15; b >= 0; b = b - 1)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ p[b]) ? `ADST_CRC_POLY : 16'h0000);
            p = pnStep(p);
        end
        sigCalc = c;
    endfunction
    function automatic [7:0] corr(input [15:0] c);
        integer s;
        integer j;
        s = c[15:14];
        for (j = 0; j < 7; j++) s += c[2*j +: 2] << (6 - j);
        corr = (s > 255) ? 8'hFF : s[7:0];
    endfunction
    function automatic [15:0] rndCode();
        integer j;
        for (j = 0; j < 8; j++) rndCode[2*j +: 2] = 2'($unsigned($random(seed)) % 3);
    endfunction

    adst_core #(.EXPECT_SIG(sigCalc(512))) dut_u (.ref_clk, .arst_n, .clkEn, .outDisable, .powerDown,
        .fmtTwosComp, .stageCodeA, .stageCodeB, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_r,
        .chAData_r, .chBData_r, .chAOe_r, .chBOe_r, .outValid_r, .outReady, .selfCheckBusy_r);
    adst_rx_model rx_u (.ref_clk, .arst_n, .clkEn, .stallEn, .chA(chAData_r), .chB(chBData_r), .aOe(chAOe_r),
        .bOe(chBOe_r), .outValid(outValid_r), .outReady, .rxStrobe, .rxWord);

    always #50 ref_clk = ~ref_clk;

    task chkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chkReg(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(negedge ref_clk);
        regRdEn = 1'b1;
        regAddr = a;
        rdQ.push_back(e);
        @(negedge ref_clk);
        regRdEn = 1'b0;
    endtask
    task doReset;
        arst_n = 1'b0;
        tick(3);
        arst_n = 1'b1;
    endtask
    task waitDrain;
        for (k = 0; k < 3000 && (expQ.size() != 0 || selfCheckBusy_r !== 1'b0); k++) tick(1);
        chkWord("pending words", 16'h0000, 16'(expQ.size()));
    endtask
    task tallyAndFinish;
        $display("Checks %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // Result watchers and random stimulus
    // ****************************************************************
    always @(posedge ref_clk) rdPend <= regRdEn && clkEn && arst_n;
    always @(negedge ref_clk) begin
        if (rdPend) chkReg("register", rdQ.pop_front(), regRdData_r);
        // Stale words ahead of a self-test run are skipped
        if (rxStrobe && expQ.size() != 0 && !(syncWait && rxWord !== expQ[0])) begin
            syncWait = 1'b0;
            chkWord("word", expQ.pop_front(), rxWord);
        end
        clkEn = !stallEn || ($random(seed) % 4 != 0);
        if (randStage) begin
            stageCodeA = 16'($random(seed));
            stageCodeB = 16'($random(seed));
        end
    end

    initial begin
        #6000000;
        numErrors++;
        tallyAndFinish;
    end

    initial begin
        doReset;
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h00);
        rd(8'h33, 8'h00);
        tick(2);
        $display("Test register reset done");
        for (i = 0; i < 2; i++) begin
            if (i == 0) outDisable = 1'b1;
            else powerDown = 1'b1;
            tick(4);
            chkReg("enables off", 8'h00, {6'h00, chAOe_r, chBOe_r});
            outDisable = 1'b0;
            powerDown = 1'b0;
            tick(4);
            chkReg("enables on", 8'h03, {6'h00, chAOe_r, chBOe_r});
        end
        $display("Test output enables done");
        for (i = 0; i < 6; i++) begin
            stageCodeA = rndCode();
            stageCodeB = (i == 0) ? 16'hAAAA : rndCode();
            tick(10);
            repeat (2) expQ.push_back({corr(stageCodeB), corr(stageCodeA)});
            waitDrain;
        end
        $display("Test correction done");
        randStage = 1'b1;
        for (i = 0; i < 10; i++) begin
            wr(8'h0D, modeTab[i][16:9]);
            fmtTwosComp = modeTab[i][8];
            tick(8);
            syncWait = modeTab[i][12:9] inside {4'h4, 4'h7};
            for (k = 0; k < 3; k++) expQ.push_back({2{modeTab[i][7:0] ^ {8{syncWait & k[0]}}}});
            waitDrain;
        end
        rd(8'h0D, 8'h26);
        randStage = 1'b0;
        wr(8'h0D, 8'h00);
        stageCodeA = 16'h0000;
        stageCodeB = 16'h0000;
        fmtTwosComp = 1'b0;
        $display("Test output modes done");
        doReset;
        pn = `ADST_SELF_PN_SEED;
        for (i = 0; i < 512; i++) begin
            expQ.push_back(pn);
            pn = pnStep(pn);
        end
        syncWait = 1'b1;
        wr(8'h0E, 8'h05);
        rd(8'h0E, 8'h05);
        waitDrain;
        rd(8'h0E, 8'h05);
        $display("Test self-check pass done");
        for (i = 0; i < 512; i++) begin
            expQ.push_back(pn);
            pn = pnStep(pn);
        end
        syncWait = 1'b1;
        wr(8'h0E, 8'h01);
        stallEn = 1'b1;
        waitDrain;
        stallEn = 1'b0;
        tick(2);
        rd(8'h0E, 8'h00);
        tick(4);
        $display("Test self-check continue done");
        tallyAndFinish;
    end
endmodule
